// ---- verilog/tcc_pkg.sv ----
`default_nettype none
package tcc_pkg;
	// -----------------------------------------------------------------
	// Register byte offsets on the APB port
	// -----------------------------------------------------------------
	localparam logic [7:0] TCC_OFS_COUNT    = 8'h00;
	localparam logic [7:0] TCC_OFS_CCP      = 8'h04;
	localparam logic [7:0] TCC_OFS_MODE     = 8'h08;
	localparam logic [7:0] TCC_OFS_CAPCOMP  = 8'h0C;
	localparam logic [7:0] TCC_OFS_PRESCALE = 8'h10;
	localparam logic [7:0] TCC_OFS_STATUS   = 8'h14;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int TCC_MODE_OVF_BIT  = 0;
	localparam int TCC_MODE_LO_BIT   = 2;
	localparam int TCC_MODE_HI_BIT   = 3;
	localparam int TCC_MODE_OSPT_BIT = 4;
	localparam int TCC_CC_FUNC_BIT   = 0;
	localparam int TCC_CC_SRC_BIT    = 1;
	localparam int TCC_PRM_CLK_LO    = 0;
	localparam int TCC_PRM_PRI_LO    = 4;
	localparam int TCC_PRM_SEC_LO    = 6;
	localparam int TCC_STAT_MATCH    = 0;
	localparam int TCC_STAT_CAPT     = 1;

	// -----------------------------------------------------------------
	// Reset values and counts
	// -----------------------------------------------------------------
	localparam logic [15:0] TCC_COUNT_RST  = 16'h0000;
	localparam logic [15:0] TCC_CCP_RST    = 16'h0000;
	localparam logic [15:0] TCC_COUNT_MAX  = 16'hFFFF;
	localparam logic [7:0]  TCC_REG8_RST   = 8'h00;
	localparam int          TCC_FILTER_LEN = 3;
	localparam int          TCC_DIV_W      = 8;

	// Operating modes held in the two mode select bits
	typedef enum logic [1:0] {
		TCC_MODE_STOP  = 2'b00,
		TCC_MODE_FREE  = 2'b01,
		TCC_MODE_EDGE  = 2'b10,
		TCC_MODE_MATCH = 2'b11
	} tcc_mode_t;

	// Edge select codes, 2'b10 is forbidden for software
	localparam logic [1:0] TCC_EDGE_FALL = 2'b00;
	localparam logic [1:0] TCC_EDGE_RISE = 2'b01;
	localparam logic [1:0] TCC_EDGE_BOTH = 2'b11;

	// Filtered pin edge pair
	typedef struct packed {
		logic rise;
		logic fall;
	} tcc_edge_t;
endpackage
`default_nettype wire

// ---- verilog/tcc_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcc_filter #(
	parameter int LEN = tcc_pkg::TCC_FILTER_LEN
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             pin,
	output var  tcc_pkg::tcc_edge_t edge_o
);
	// -----------------------------------------------------------------
	// Synchroniser and noise filter
	// -----------------------------------------------------------------
	logic           sync_a;
	logic           sync_b;
	logic [LEN-1:0] hist;
	logic           level;

	// Two flops; only sync_b is looked at
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
		end
	end

	// Level only moves after LEN equal samples, so glitches die here
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hist  <= '0;
			level <= 1'b0;
		end else begin
			hist <= {hist[LEN-2:0], sync_b};
			if (&hist)
				level <= 1'b1;
			else if (~|hist)
				level <= 1'b0;
		end
	end

	// One-cycle edge pulses from the filtered level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			edge_o <= '0;
		end else begin
			edge_o.rise <= (&hist) & ~level;
			edge_o.fall <= (~|hist) & level;
		end
	end
endmodule // tcc_filter
`default_nettype wire

// ---- verilog/tcc_timer.sv ----
// Summary of operation
// - Read-only 16-bit counter steps by one on each count clock tick.
// - Reset forces the counter to zero.
// - Mode bits both zero stop and clear the counter.
// - Edge-clear mode zeroes the counter on a valid primary input edge.
// - Match-clear mode zeroes the counter when it equals the compare value.
// - Setting the one-shot trigger bit zeroes the counter.
// - Function bit 0 makes the primary register compare or capture.
// - Primary capture/compare register resets to zero.
// - Compare continuously, pulse the match request, hold value until written.
// - Primary-pin capture uses the opposite edge; both-edges means none.
// - Secondary-pin capture uses the programmed edge directly.
// - Primary edge select in prescaler bits 5:4, secondary in 7:6.
// - Capture source is bit 1, function select bit 0 of control.
// - Zero compare value matches as the count steps 0000 to 0001.
// - Capture during a read still stores the correct value.
// - Capture coinciding with a stop may store any value.
// - Mode codes: 00 stop, 01 free, 10 edge clear, 11 match clear.
// - Counting starts once the mode bits leave 00.
// - Wrap from FFFF to 0000 sets the overflow flag.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer #(
	parameter int DIV_W = tcc_pkg::TCC_DIV_W
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        primary_timer_input,
	input  wire logic        secondary_timer_input,
	output logic             primary_match_irq,
	output logic             capture_event
);
	// -----------------------------------------------------------------
	// Registers and state
	// -----------------------------------------------------------------
	// Software-visible registers first, then internal state
	logic [15:0]      timer_count_value;
	logic [15:0]      capture_compare_primary;
	logic [7:0]       timer_mode_control;
	logic [7:0]       capcomp_control;
	logic [7:0]       prescaler_edge_reg;
	logic [1:0]       status;
	logic [DIV_W-1:0] div_cnt;
	logic [15:0]      prev_count;
	logic             prev_tick;

	tcc_pkg::tcc_edge_t pri_edge;
	tcc_pkg::tcc_edge_t sec_edge;

	// -----------------------------------------------------------------
	// Input filters
	// -----------------------------------------------------------------
	// Same filter on both pins, so their edge delays match
	tcc_filter u_pri_filter (
		.clk    (clk),
		.rstn   (rstn),
		.pin    (primary_timer_input),
		.edge_o (pri_edge)
	);

	tcc_filter u_sec_filter (
		.clk    (clk),
		.rstn   (rstn),
		.pin    (secondary_timer_input),
		.edge_o (sec_edge)
	);

	// -----------------------------------------------------------------
	// Decoded control
	// -----------------------------------------------------------------
	// Fields and strobes taken straight from the registers and the bus
	tcc_pkg::tcc_mode_t mode;
	logic [1:0]         pri_sel;
	logic [1:0]         sec_sel;
	logic [1:0]         clk_sel;
	logic               is_capture;
	logic               src_primary;
	logic               running;
	logic               tick;
	logic               pri_valid;
	logic               sec_valid;
	logic               pri_capt;
	logic               capt_trig;
	logic               match;
	logic               wr;
	logic               rd;
	logic               ospt_set;

	// Mode bits packed into the enum
	assign mode = tcc_pkg::tcc_mode_t'({
		timer_mode_control[tcc_pkg::TCC_MODE_HI_BIT],
		timer_mode_control[tcc_pkg::TCC_MODE_LO_BIT]});
	assign running = (mode != tcc_pkg::TCC_MODE_STOP);
	assign pri_sel = prescaler_edge_reg[tcc_pkg::TCC_PRM_PRI_LO +: 2];
	assign sec_sel = prescaler_edge_reg[tcc_pkg::TCC_PRM_SEC_LO +: 2];
	assign clk_sel = prescaler_edge_reg[tcc_pkg::TCC_PRM_CLK_LO +: 2];
	assign is_capture  = capcomp_control[tcc_pkg::TCC_CC_FUNC_BIT];
	assign src_primary = capcomp_control[tcc_pkg::TCC_CC_SRC_BIT];

	// Bus strobes; zero wait states
	// Writes land on the access edge, where pready is high
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign ospt_set = wr && (paddr == tcc_pkg::TCC_OFS_MODE)
		&& pwdata[tcc_pkg::TCC_MODE_OSPT_BIT];

	// Count clock: /1, /4, /256 or /2^DIV_W of clk
	// The last two only differ once DIV_W is raised above 8
	always_comb begin
		case (clk_sel)
			2'd0:    tick = running;
			2'd1:    tick = running & (&div_cnt[1:0]);
			2'd2:    tick = running & (&div_cnt[7:0]);
			default: tick = running & (&div_cnt);
		endcase
	end

	// Primary pin valid edge as programmed
	// The forbidden code 2'b10 falls to the default, both edges
	always_comb begin
		case (pri_sel)
			tcc_pkg::TCC_EDGE_FALL: pri_valid = pri_edge.fall;
			tcc_pkg::TCC_EDGE_RISE: pri_valid = pri_edge.rise;
			default:                pri_valid = pri_edge.rise | pri_edge.fall;
		endcase
	end

	// Primary-pin capture works on the opposite edge
	// Both edges, and the forbidden code, capture nothing
	always_comb begin
		case (pri_sel)
			tcc_pkg::TCC_EDGE_FALL: pri_capt = pri_edge.rise;
			tcc_pkg::TCC_EDGE_RISE: pri_capt = pri_edge.fall;
			default:                pri_capt = 1'b0;
		endcase
	end

	// Secondary pin uses the programmed edge as is
	// The forbidden code acts as both edges here too
	always_comb begin
		case (sec_sel)
			tcc_pkg::TCC_EDGE_FALL: sec_valid = sec_edge.fall;
			tcc_pkg::TCC_EDGE_RISE: sec_valid = sec_edge.rise;
			default:                sec_valid = sec_edge.rise | sec_edge.fall;
		endcase
	end

	// Capture only while running; a stop written in the same cycle still
	// takes the count before it clears, one of the values allowed then
	assign capt_trig = is_capture & running
		& (src_primary ? pri_capt : sec_valid);

	// Match seen one tick after the count lands on the compare value,
	// so a zero compare fires on the 0000 to 0001 step after a wrap
	// A zero compare also fires on the first step after a start
	assign match = ~is_capture & running & prev_tick
		& (prev_count == capture_compare_primary);

	// -----------------------------------------------------------------
	// Prescaler divider
	// -----------------------------------------------------------------
	// Divider held at zero while stopped so the first tick is fixed
	// No divider phase is kept across a stop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			div_cnt <= '0;
		else if (!running)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 1'b1;
	end

	// -----------------------------------------------------------------
	// Counter
	// -----------------------------------------------------------------
	// Clears rank above counting; match clear only in match mode
	// One-shot trigger clears in any running mode, not only one-shot
	// A clear and a tick in one cycle leave zero; that tick is lost
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			timer_count_value <= tcc_pkg::TCC_COUNT_RST;
		else if (!running)
			timer_count_value <= tcc_pkg::TCC_COUNT_RST;
		else if (ospt_set)
			timer_count_value <= tcc_pkg::TCC_COUNT_RST;
		else if (mode == tcc_pkg::TCC_MODE_EDGE && pri_valid)
			timer_count_value <= tcc_pkg::TCC_COUNT_RST;
		else if (tick && mode == tcc_pkg::TCC_MODE_MATCH && !is_capture
				&& timer_count_value == capture_compare_primary)
			timer_count_value <= tcc_pkg::TCC_COUNT_RST;
		else if (tick)
			timer_count_value <= timer_count_value + 1'b1;
	end

	// Track the last stepped value for the match decode
	// Costs one cycle on the request but keeps the compare path short
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_count <= tcc_pkg::TCC_COUNT_RST;
			prev_tick  <= 1'b0;
		end else begin
			prev_count <= timer_count_value;
			prev_tick  <= tick;
		end
	end

	// -----------------------------------------------------------------
	// Capture/compare register
	// -----------------------------------------------------------------
	// Capture wins over a bus write; the stored value stays correct
	// even if a read lands in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			capture_compare_primary <= tcc_pkg::TCC_CCP_RST;
		else if (capt_trig)
			capture_compare_primary <= timer_count_value;
		else if (wr && paddr == tcc_pkg::TCC_OFS_CCP)
			capture_compare_primary <= pwdata[15:0];
	end

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------
	// Overflow set wins over a software clear; trigger bit is not kept
	// Trigger bit only pulses the clear and always reads back zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			timer_mode_control <= tcc_pkg::TCC_REG8_RST;
		else begin
			if (wr && paddr == tcc_pkg::TCC_OFS_MODE)
				timer_mode_control <= {4'h0, pwdata[3:0]};
			if (tick && timer_count_value == tcc_pkg::TCC_COUNT_MAX)
				timer_mode_control[tcc_pkg::TCC_MODE_OVF_BIT] <= 1'b1;
		end
	end

	// Function and source select, only two bits kept
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			capcomp_control <= tcc_pkg::TCC_REG8_RST;
		else if (wr && paddr == tcc_pkg::TCC_OFS_CAPCOMP)
			capcomp_control <= {6'h00, pwdata[1:0]};
	end

	// Clock select and both edge selects, all eight bits kept
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			prescaler_edge_reg <= tcc_pkg::TCC_REG8_RST;
		else if (wr && paddr == tcc_pkg::TCC_OFS_PRESCALE)
			prescaler_edge_reg <= pwdata[7:0];
	end

	// Sticky event status, write one to clear; a new event wins
	// Later assignments win, so a clear cannot swallow an event
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			status <= 2'b00;
		else begin
			if (wr && paddr == tcc_pkg::TCC_OFS_STATUS)
				status <= status & ~pwdata[1:0];
			if (match)
				status[tcc_pkg::TCC_STAT_MATCH] <= 1'b1;
			if (capt_trig)
				status[tcc_pkg::TCC_STAT_CAPT] <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Event outputs
	// -----------------------------------------------------------------
	// Capture also raises the request, as the mode table lists
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			primary_match_irq <= 1'b0;
			capture_event     <= 1'b0;
		end else begin
			primary_match_irq <= match | capt_trig;
			capture_event     <= capt_trig;
		end
	end

	// -----------------------------------------------------------------
	// APB read side
	// -----------------------------------------------------------------
	logic [31:0] next_prdata;
	logic        next_pslverr;

	// Read mux; an unmapped offset answers zero and flags an error
	always_comb begin
		next_prdata  = '0;
		next_pslverr = 1'b0;
		case (paddr)
			tcc_pkg::TCC_OFS_COUNT:
				next_prdata = {16'h0000, timer_count_value};
			tcc_pkg::TCC_OFS_CCP:
				next_prdata = {16'h0000, capture_compare_primary};
			tcc_pkg::TCC_OFS_MODE:
				next_prdata = {24'h00_0000, timer_mode_control};
			tcc_pkg::TCC_OFS_CAPCOMP:
				next_prdata = {24'h00_0000, capcomp_control};
			tcc_pkg::TCC_OFS_PRESCALE:
				next_prdata = {24'h00_0000, prescaler_edge_reg};
			tcc_pkg::TCC_OFS_STATUS:
				next_prdata = {30'h0000_0000, status};
			default:
				next_pslverr = 1'b1;
		endcase
	end

	// Taken in the setup cycle so the access phase never waits; a read
	// that meets a capture shows the old count, the register stays right
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & next_pslverr;
			if (psel && !penable)
				prdata <= next_prdata;
		end
	end

	// Unused upper write bits are dropped on purpose
	// Read strobe is not needed: reads have no side effect
	logic unused_ok;
	assign unused_ok = &{1'b0, rd, pwdata[31:16]};
endmodule // tcc_timer
`default_nettype wire

// ---- sim/tcc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcc_checker (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        primary_timer_input,
	input wire logic        secondary_timer_input,
	input wire logic        primary_match_irq,
	input wire logic        capture_event
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ----------------------------------------------------------------
	// Bus phases
	// ----------------------------------------------------------------
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	// Wait-free slave: access always completes at once
	property p_ready; s_setup |=> s_access; endproperty
	property p_one; pready |=> !pready; endproperty
	property p_err;
		pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0000_0000;
	endproperty
	property p_noerr;
		pready && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr;
	endproperty
	property p_upper;
		pready && !pwrite |-> prdata[31:16] == 16'h0000;
	endproperty
	property p_cap; capture_event |=> !capture_event; endproperty
	property p_irq; primary_match_irq |=> !primary_match_irq; endproperty
	// Filter delay: no capture right after a secondary pin change
	property p_filt;
		$changed(secondary_timer_input) |-> !capture_event [*3];
	endproperty
	a_ready: assert property (p_ready) else $error("no access answer");
	a_one: assert property (p_one) else $error("pready too long");
	a_err: assert property (p_err) else $error("unmapped not refused");
	a_noerr: assert property (p_noerr) else $error("mapped refused");
	a_upper: assert property (p_upper) else $error("upper bits set");
	a_cap: assert property (p_cap) else $error("capture pulse long");
	a_irq: assert property (p_irq) else $error("irq pulse long");
	a_filt: assert property (p_filt) else $error("unfiltered edge");
endmodule // tcc_checker
bind tcc_timer tcc_checker u_chk (
	.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.primary_timer_input(primary_timer_input),
	.secondary_timer_input(secondary_timer_input),
	.primary_match_irq(primary_match_irq), .capture_event(capture_event)
);
`default_nettype wire

// ---- sim/tcc_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcc_pins (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [1:0] want,
	output logic            primary_timer_input,
	output logic            secondary_timer_input
);
	// Pulse source; the secondary pin is driven from want[1], the primary from want[0]
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			primary_timer_input   <= 1'b0;
			secondary_timer_input <= 1'b0;
		end else begin
			primary_timer_input   <= want[0];
			secondary_timer_input <= want[1];
		end
	end
endmodule // tcc_pins
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [1:0]  pin_want = 2'b00;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pri_pin;
	logic        sec_pin;
	logic        irq;
	logic        cap;
	logic [31:0] rd;
	logic [31:0] a;
	logic        err;
	int          errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          caps = 0;
	int          irqs = 0;
	int          seed = 32'h0000_7844;
	always #2.5 clk = ~clk;
	tcc_timer #(.DIV_W(8)) uut (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .primary_timer_input(pri_pin),
		.secondary_timer_input(sec_pin), .primary_match_irq(irq),
		.capture_event(cap)
	);
	tcc_pins u_pins (
		.clk(clk), .rstn(rstn), .want(pin_want),
		.primary_timer_input(pri_pin), .secondary_timer_input(sec_pin)
	);
	// ----------------------------------------------------------------
	// Closing, comparison and bus tasks
	// ----------------------------------------------------------------
	task automatic print_verdict;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0000_0000);
		check(rd, exp);
	endtask
	task automatic do_reset;
		rstn <= 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
	endtask
	// Model of the capture edge tables; pin 1 is the primary input
	function automatic logic [31:0] exp_cap(int p, int code, int rise);
		if (code == 3) return p ? 0 : 1;
		return p ^ ((code == 1) ? rise : 1 - rise);
	endfunction
	// Move one pin and count the captures it causes
	task automatic pin_step(int p, logic lvl, logic [31:0] e);
		int c0;
		@(posedge clk);
		if (p) pin_want[0] <= lvl;
		else pin_want[1] <= lvl;
		c0 = caps;
		repeat (14) @(posedge clk);
		check(caps - c0, e);
	endtask
	// Cycle count, event counts and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cap === 1'b1) caps <= caps + 1;
		if (irq === 1'b1) irqs <= irqs + 1;
		if (cycles == 90000) begin
			errors++;
			print_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int i;
		int p;
		int code;
		do_reset();
		for (i = 0; i < 6; i++) rc(8'(i * 4), 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
		repeat (4) begin
			a = $random(seed);
			wr(tcc_pkg::TCC_OFS_CCP, a);
			rc(tcc_pkg::TCC_OFS_CCP, a & 32'h0000_FFFF);
		end
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0004);
		apb(1'b0, tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		a = rd;
		apb(1'b0, tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		check(rd - a, 32'h0000_0003);
		repeat (100) @(posedge clk);
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0014);
		apb(1'b0, tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		check(32'(rd < 8), 32'h0000_0001);
		rc(tcc_pkg::TCC_OFS_MODE, 32'h0000_0004);
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0000);
		rc(tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		repeat (20) @(posedge clk);
		rc(tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		// Divided count clock
		wr(tcc_pkg::TCC_OFS_PRESCALE, 32'h0000_0001);
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0004);
		apb(1'b0, tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		a = rd;
		repeat (8) apb(1'b0, tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		check(32'(rd - a >= 5 && rd - a <= 7), 32'h0000_0001);
		// Both slow count clock selects: four ticks in 1031 cycles
		for (i = 2; i < 4; i++) begin
			wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0000);
			wr(tcc_pkg::TCC_OFS_PRESCALE, i);
			wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0004);
			repeat (1030) @(posedge clk);
			rc(tcc_pkg::TCC_OFS_COUNT, 32'h0000_0004);
		end
		// Clear on primary rising edge
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0000);
		wr(tcc_pkg::TCC_OFS_PRESCALE, 32'h0000_0010);
		wr(tcc_pkg::TCC_OFS_CAPCOMP, 32'h0000_0000);
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0008);
		repeat (100) @(posedge clk);
		pin_step(1, 1'b1, 32'h0000_0000);
		apb(1'b0, tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		check(32'(rd < 20), 32'h0000_0001);
		pin_step(1, 1'b0, 32'h0000_0000);
		// Clear on match, value never passes compare
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0000);
		wr(tcc_pkg::TCC_OFS_CCP, 32'h0000_000A);
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_000C);
		a = irqs;
		repeat (6) begin
			apb(1'b0, tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
			check(32'(rd <= 10), 32'h0000_0001);
		end
		check(32'(irqs - a >= 1), 32'h0000_0001);
		// Every edge code on both capture sources, never code 2'b10
		for (p = 0; p < 2; p++) begin
			for (i = 0; i < 3; i++) begin
				code = (i == 2) ? 3 : i;
				wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0000);
				wr(tcc_pkg::TCC_OFS_PRESCALE, p ? code << 4 : code << 6);
				wr(tcc_pkg::TCC_OFS_CAPCOMP, p ? 32'h0000_0003 : 32'h0000_0001);
				wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0004);
				pin_step(p, 1'b1, exp_cap(p, code, 1));
				pin_step(p, 1'b0, exp_cap(p, code, 0));
			end
		end
		apb(1'b0, tcc_pkg::TCC_OFS_CCP, 32'h0000_0000);
		a = rd;
		apb(1'b0, tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		check(32'(rd - a >= 6 && rd - a <= 24), 32'h0000_0001);
		// Zero compare and wrap of the full count
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0000);
		wr(tcc_pkg::TCC_OFS_CAPCOMP, 32'h0000_0000);
		wr(tcc_pkg::TCC_OFS_CCP, 32'h0000_0000);
		wr(tcc_pkg::TCC_OFS_STATUS, 32'h0000_0003);
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0004);
		// Drop the match from the start step so only the wrap can set it
		repeat (100) @(posedge clk);
		wr(tcc_pkg::TCC_OFS_STATUS, 32'h0000_0003);
		rc(tcc_pkg::TCC_OFS_STATUS, 32'h0000_0000);
		repeat (65460) @(posedge clk);
		rc(tcc_pkg::TCC_OFS_MODE, 32'h0000_0005);
		rc(tcc_pkg::TCC_OFS_STATUS, 32'h0000_0001);
		wr(tcc_pkg::TCC_OFS_MODE, 32'h0000_0004);
		rc(tcc_pkg::TCC_OFS_MODE, 32'h0000_0004);
		do_reset();
		rc(tcc_pkg::TCC_OFS_COUNT, 32'h0000_0000);
		rc(tcc_pkg::TCC_OFS_CCP, 32'h0000_0000);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
